/* File: logic/stl_pkg.sv */
// Package for the per-quad transmitter level select block
package stl_pkg;

  // Register map, byte offsets on the plain register port
  localparam logic [3:0] STL_OFS_CTRL_A = 4'h0;
  localparam logic [3:0] STL_OFS_CTRL_B = 4'h4;
  localparam logic [3:0] STL_OFS_STATUS = 4'h8;

  // Field widths
  localparam int STL_DRV_W = 5;
  localparam int STL_FDE_W = 3;
  localparam int STL_CDE_W = 2;
  localparam int STL_EQ_W = 2;
  localparam int STL_CSL_W = 2;
  localparam int STL_FSL_W = 2;

  // Control register A field positions
  localparam int STL_A_CDE_R1_35 = 0;
  localparam int STL_A_EQ_R1_35 = 2;
  localparam int STL_A_CDE_R2_35 = 4;
  localparam int STL_A_EQ_R2_35 = 6;
  localparam int STL_A_CDE_R2_60 = 8;
  localparam int STL_A_EQ_R2_60 = 10;
  localparam int STL_A_CSL_R1 = 12;
  localparam int STL_A_FSL_R1 = 14;
  localparam int STL_A_CSL_R2 = 16;
  localparam int STL_A_FSL_R2 = 18;

  // Control register B field positions
  localparam int STL_B_DRV_R1_35 = 0;
  localparam int STL_B_FDE_R1_35 = 5;
  localparam int STL_B_DRV_R2_35 = 8;
  localparam int STL_B_FDE_R2_35 = 13;
  localparam int STL_B_DRV_R2_60 = 16;
  localparam int STL_B_FDE_R2_60 = 21;
  localparam int STL_B_DRV_LOW_R1 = 24;
  localparam int STL_B_DRV_LOW_R2 = 29;

  // Reset values: defaults for every mode
  localparam logic [31:0] STL_RST_CTRL_A = 32'h00003B37;
  localparam logic [31:0] STL_RST_CTRL_B = 32'h19DC63DC;
  localparam logic [31:0] STL_MASK_CTRL_A = 32'h000FFFFF;
  localparam logic [31:0] STL_MASK_CTRL_B = 32'hFFFFFFFF;

  // Operating modes, gray coded along the usual path
  typedef enum logic [2:0] {
    STL_FULL_R1_35 = 3'b000,
    STL_FULL_R2_35 = 3'b001,
    STL_FULL_R2_60 = 3'b011,
    STL_LOW_R2 = 3'b010,
    STL_LOW_R1 = 3'b110
  } stl_mode_t;

  // PHY state carried into the block
  typedef struct packed {
    logic rateR2;
    logic lowSwing;
    logic deemph60;
  } stl_phy_t;

  // Settings driven to the transmitter
  typedef struct packed {
    logic [4:0] driveLevel;
    logic [2:0] fineDeemph;
    logic [1:0] coarseDeemph;
    logic [1:0] txEqual;
    logic [1:0] coarseSlew;
    logic [1:0] fineSlew;
    logic deemphOn;
  } stl_tx_t;

endpackage : stl_pkg

/* File: logic/stl_level_select.sv */
// Transmitter level select for one transceiver quad
//
// What this block does
// [R1] Two control registers hold settings for five PHY modes, with slew shared per rate.
// [R2] Registers reset to usable defaults for every mode; software may overwrite.
// [R3] PHY mode change automatically drives the new mode's field set.
// [R4] Full swing, rate 1, -3.5 dB uses its own fields and rate 1 slew.
// [R5] Full swing, rate 2, -3.5 dB uses its own fields and rate 2 slew.
// [R6] Full swing, rate 2, -6.0 dB uses its dedicated fields.
// [R7] Low swing rate 1: no de-emphasis, rate 1 slew, low drive field.
// [R8] Low swing rate 2: no de-emphasis, rate 2 slew, low drive field; the code takes only bits 31:29 of it, zero-extended to 5 bits.
// [R9] Register A holds coarse and fine slew, equalization, coarse de-emphasis.
// [R10] Register B holds fine de-emphasis and drive levels.
// [R11] Writing an active-mode field changes driven settings at once.
// [R12] No link retrain is needed for new settings to apply.
// [R13] Software should take care changing margin during normal operation.
// [R14] Rate 1 tuning guide: drive up to 0x1C, eq 0x2, cde 0x3, slew 0x2.
// [R15] Mode follows only rate, swing and de-emphasis, one cycle later.
`timescale 1ns/10ps

module stl_level_select
  import stl_pkg::*;
(
  input wire logic clk, // 200 MHz clock
  input wire logic nrst, // Async reset, low
  input wire logic clkEn, // Freezes all state when low
  input wire stl_pkg::stl_phy_t phyState, // Current PHY rate, swing, de-emphasis
  input wire logic [3:0] regAddr, // Register byte offset
  input wire logic [31:0] regWrData, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [31:0] regRdData, // Read data, cycle after strobe
  output stl_pkg::stl_tx_t txSettings, // Settings to the transmitter
  output stl_pkg::stl_mode_t activeMode // Currently applied mode
);
  import stl_pkg::*;

  logic [31:0] quad_tx_ctrl_a;
  logic [31:0] quad_tx_ctrl_b;
  stl_mode_t next_mode;
  stl_tx_t next_tx;
  logic [31:0] next_rd;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  // [R1] [R2] [R9] Register A with defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quad_tx_ctrl_a <= STL_RST_CTRL_A;
    end else if (clkEn && regWrite && regAddr == STL_OFS_CTRL_A) begin
      quad_tx_ctrl_a <= regWrData & STL_MASK_CTRL_A;
    end
  end

  // [R1] [R2] [R10] Register B with defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      quad_tx_ctrl_b <= STL_RST_CTRL_B;
    end else if (clkEn && regWrite && regAddr == STL_OFS_CTRL_B) begin
      quad_tx_ctrl_b <= regWrData & STL_MASK_CTRL_B;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    unique case (regAddr)
      STL_OFS_CTRL_A: next_rd = quad_tx_ctrl_a;
      STL_OFS_CTRL_B: next_rd = quad_tx_ctrl_b;
      STL_OFS_STATUS: next_rd = {29'h0000000, activeMode};
      default: next_rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 32'h00000000;
    end else if (clkEn) begin
      regRdData <= regRead ? next_rd : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode tracking

  // [R15] Mode from rate, swing and de-emphasis only
  always_comb begin
    if (phyState.lowSwing) begin
      next_mode = phyState.rateR2 ? STL_LOW_R2 : STL_LOW_R1;
    end else if (!phyState.rateR2) begin
      next_mode = STL_FULL_R1_35;
    end else begin
      next_mode = phyState.deemph60 ? STL_FULL_R2_60 : STL_FULL_R2_35;
    end
  end

  // [R3] Mode register follows PHY
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      activeMode <= STL_FULL_R1_35;
    end else if (clkEn) begin
      activeMode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field set selection

  always_comb begin
    next_tx = '0;
    unique case (activeMode)
      // [R4] Rate 1 full swing fields
      STL_FULL_R1_35: begin
        next_tx.coarseDeemph = quad_tx_ctrl_a[STL_A_CDE_R1_35 +: STL_CDE_W];
        next_tx.txEqual = quad_tx_ctrl_a[STL_A_EQ_R1_35 +: STL_EQ_W];
        next_tx.coarseSlew = quad_tx_ctrl_a[STL_A_CSL_R1 +: STL_CSL_W];
        next_tx.fineSlew = quad_tx_ctrl_a[STL_A_FSL_R1 +: STL_FSL_W];
        next_tx.driveLevel = quad_tx_ctrl_b[STL_B_DRV_R1_35 +: STL_DRV_W];
        next_tx.fineDeemph = quad_tx_ctrl_b[STL_B_FDE_R1_35 +: STL_FDE_W];
        next_tx.deemphOn = 1'b1;
      end
      // [R5] Rate 2, -3.5 dB fields
      STL_FULL_R2_35: begin
        next_tx.coarseDeemph = quad_tx_ctrl_a[STL_A_CDE_R2_35 +: STL_CDE_W];
        next_tx.txEqual = quad_tx_ctrl_a[STL_A_EQ_R2_35 +: STL_EQ_W];
        next_tx.coarseSlew = quad_tx_ctrl_a[STL_A_CSL_R2 +: STL_CSL_W];
        next_tx.fineSlew = quad_tx_ctrl_a[STL_A_FSL_R2 +: STL_FSL_W];
        next_tx.driveLevel = quad_tx_ctrl_b[STL_B_DRV_R2_35 +: STL_DRV_W];
        next_tx.fineDeemph = quad_tx_ctrl_b[STL_B_FDE_R2_35 +: STL_FDE_W];
        next_tx.deemphOn = 1'b1;
      end
      // [R6] Rate 2, -6.0 dB fields
      STL_FULL_R2_60: begin
        next_tx.coarseDeemph = quad_tx_ctrl_a[STL_A_CDE_R2_60 +: STL_CDE_W];
        next_tx.txEqual = quad_tx_ctrl_a[STL_A_EQ_R2_60 +: STL_EQ_W];
        next_tx.coarseSlew = quad_tx_ctrl_a[STL_A_CSL_R2 +: STL_CSL_W];
        next_tx.fineSlew = quad_tx_ctrl_a[STL_A_FSL_R2 +: STL_FSL_W];
        next_tx.driveLevel = quad_tx_ctrl_b[STL_B_DRV_R2_60 +: STL_DRV_W];
        next_tx.fineDeemph = quad_tx_ctrl_b[STL_B_FDE_R2_60 +: STL_FDE_W];
        next_tx.deemphOn = 1'b1;
      end
      // [R7] Low swing rate 1, de-emphasis off
      STL_LOW_R1: begin
        next_tx.coarseSlew = quad_tx_ctrl_a[STL_A_CSL_R1 +: STL_CSL_W];
        next_tx.fineSlew = quad_tx_ctrl_a[STL_A_FSL_R1 +: STL_FSL_W];
        next_tx.driveLevel = quad_tx_ctrl_b[STL_B_DRV_LOW_R1 +: STL_DRV_W];
      end
      // [R8] Low swing rate 2, de-emphasis off
      STL_LOW_R2: begin
        next_tx.coarseSlew = quad_tx_ctrl_a[STL_A_CSL_R2 +: STL_CSL_W];
        next_tx.fineSlew = quad_tx_ctrl_a[STL_A_FSL_R2 +: STL_FSL_W];
        next_tx.driveLevel = 5'(quad_tx_ctrl_b[31:STL_B_DRV_LOW_R2]);
      end
      default: next_tx = '0;
    endcase
  end

  // [R11] [R12] Output follows registers directly, no retrain gate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txSettings <= '0;
    end else if (clkEn) begin
      txSettings <= next_tx;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_mode_follows_phy: // [R15]
    assert property (@(posedge clk) disable iff (!nrst)
      clkEn |=> activeMode == $past(next_mode))
    else $error("mode did not follow phy state");

  a_low_no_deemph: // [R7]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && (activeMode == STL_LOW_R1 || activeMode == STL_LOW_R2))
      |=> !txSettings.deemphOn && txSettings.coarseDeemph == 2'h0)
    else $error("de-emphasis on in low swing");

  a_r1_drive_used: // [R4]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_FULL_R1_35)
      |=> txSettings.driveLevel == $past(quad_tx_ctrl_b[4:0]))
    else $error("rate 1 drive field not applied");

  a_r2_35_eq_used: // [R5]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_FULL_R2_35)
      |=> txSettings.txEqual == $past(quad_tx_ctrl_a[7:6]))
    else $error("rate 2 equalization not applied");

  a_r2_60_drive: // [R6]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_FULL_R2_60)
      |=> txSettings.driveLevel == $past(quad_tx_ctrl_b[20:16]))
    else $error("-6 dB drive field not applied");

  a_low_r2_drive: // [R8]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_LOW_R2)
      |=> txSettings.driveLevel == $past(quad_tx_ctrl_b[STL_B_DRV_LOW_R2 +: 3]))
    else $error("low swing rate 2 drive not applied");

  a_write_applies: // [R11]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regWrite && regAddr == STL_OFS_CTRL_B && activeMode == STL_FULL_R1_35
       && next_mode == STL_FULL_R1_35) ##1 clkEn
      |=> txSettings.driveLevel == $past(regWrData[4:0], 2))
    else $error("write did not reach transmitter");

  a_write_stores: // [R2]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regWrite && regAddr == STL_OFS_CTRL_A)
      |=> quad_tx_ctrl_a == ($past(regWrData) & STL_MASK_CTRL_A))
    else $error("register A write lost");

  a_read_one_cycle: // [R9]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regRead && regAddr == STL_OFS_CTRL_A)
      |=> regRdData == quad_tx_ctrl_a)
    else $error("register A read wrong");

  a_read_b_cycle: // [R10]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regRead && regAddr == STL_OFS_CTRL_B)
      |=> regRdData == quad_tx_ctrl_b)
    else $error("register B read wrong");

  a_write_b_stores: // [R10]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regWrite && regAddr == STL_OFS_CTRL_B)
      |=> quad_tx_ctrl_b == ($past(regWrData) & STL_MASK_CTRL_B))
    else $error("register B write lost");

  a_upper_a_zero: // [R9]
    assert property (@(posedge clk) disable iff (!nrst)
      quad_tx_ctrl_a[31:20] == 12'h000)
    else $error("unused register A bits set");

  a_no_stray_write: // [R1]
    assert property (@(posedge clk) disable iff (!nrst)
      !(clkEn && regWrite && (regAddr == STL_OFS_CTRL_A || regAddr == STL_OFS_CTRL_B))
      |=> $stable(quad_tx_ctrl_a) && $stable(quad_tx_ctrl_b))
    else $error("control register changed without write");

  a_read_status: // [R3]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regRead && regAddr == STL_OFS_STATUS)
      |=> regRdData == {29'h0000000, $past(activeMode)})
    else $error("status read wrong");

  a_read_idle_zero: // [R9]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && !regRead) |=> regRdData == 32'h00000000)
    else $error("read data not cleared");

  a_freeze_holds: // [R3]
    assert property (@(posedge clk) disable iff (!nrst)
      !clkEn |=> $stable(activeMode) && $stable(txSettings) && $stable(regRdData)
      && $stable(quad_tx_ctrl_a) && $stable(quad_tx_ctrl_b))
    else $error("state moved while clock enable low");

  a_mode_legal: // [R15]
    assert property (@(posedge clk) disable iff (!nrst)
      activeMode inside {STL_FULL_R1_35, STL_FULL_R2_35, STL_FULL_R2_60,
                         STL_LOW_R2, STL_LOW_R1})
    else $error("illegal mode code");

  a_sel_r1_35: // [R4]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && !phyState.lowSwing && !phyState.rateR2) |=> activeMode == STL_FULL_R1_35)
    else $error("rate 1 full swing not selected");

  a_sel_r2_35: // [R5]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && !phyState.lowSwing && phyState.rateR2 && !phyState.deemph60)
      |=> activeMode == STL_FULL_R2_35)
    else $error("rate 2 -3.5 dB not selected");

  a_sel_r2_60: // [R6]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && !phyState.lowSwing && phyState.rateR2 && phyState.deemph60)
      |=> activeMode == STL_FULL_R2_60)
    else $error("rate 2 -6 dB not selected");

  a_sel_low_r1: // [R7]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && phyState.lowSwing && !phyState.rateR2) |=> activeMode == STL_LOW_R1)
    else $error("low swing rate 1 not selected");

  a_sel_low_r2: // [R8]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && phyState.lowSwing && phyState.rateR2) |=> activeMode == STL_LOW_R2)
    else $error("low swing rate 2 not selected");

  a_r1_slew_used: // [R4]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && (activeMode == STL_FULL_R1_35 || activeMode == STL_LOW_R1))
      |=> txSettings.coarseSlew == $past(quad_tx_ctrl_a[13:12])
      && txSettings.fineSlew == $past(quad_tx_ctrl_a[15:14]))
    else $error("rate 1 slew not applied");

  a_r1_deemph_used: // [R4]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_FULL_R1_35)
      |=> txSettings.deemphOn && txSettings.coarseDeemph == $past(quad_tx_ctrl_a[1:0])
      && txSettings.txEqual == $past(quad_tx_ctrl_a[3:2])
      && txSettings.fineDeemph == $past(quad_tx_ctrl_b[7:5]))
    else $error("rate 1 de-emphasis not applied");

  a_r2_slew_used: // [R5]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode inside {STL_FULL_R2_35, STL_FULL_R2_60, STL_LOW_R2})
      |=> txSettings.coarseSlew == $past(quad_tx_ctrl_a[17:16])
      && txSettings.fineSlew == $past(quad_tx_ctrl_a[19:18]))
    else $error("rate 2 slew not applied");

  a_r2_35_drive: // [R5]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_FULL_R2_35)
      |=> txSettings.deemphOn && txSettings.driveLevel == $past(quad_tx_ctrl_b[12:8])
      && txSettings.fineDeemph == $past(quad_tx_ctrl_b[15:13])
      && txSettings.coarseDeemph == $past(quad_tx_ctrl_a[5:4]))
    else $error("rate 2 -3.5 dB drive not applied");

  a_r2_60_fields: // [R6]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_FULL_R2_60)
      |=> txSettings.deemphOn && txSettings.coarseDeemph == $past(quad_tx_ctrl_a[9:8])
      && txSettings.txEqual == $past(quad_tx_ctrl_a[11:10])
      && txSettings.fineDeemph == $past(quad_tx_ctrl_b[23:21]))
    else $error("-6 dB de-emphasis fields not applied");

  a_low_r1_drive: // [R7]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && activeMode == STL_LOW_R1)
      |=> txSettings.driveLevel == $past(quad_tx_ctrl_b[28:24]))
    else $error("low swing rate 1 drive not applied");

  a_low_no_eq: // [R8]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && (activeMode == STL_LOW_R1 || activeMode == STL_LOW_R2))
      |=> txSettings.txEqual == 2'h0 && txSettings.fineDeemph == 3'h0)
    else $error("equalization on in low swing");

  a_write_a_applies: // [R11]
    assert property (@(posedge clk) disable iff (!nrst)
      (clkEn && regWrite && regAddr == STL_OFS_CTRL_A && activeMode == STL_FULL_R2_35
       && next_mode == STL_FULL_R2_35) ##1 clkEn
      |=> txSettings.txEqual == $past(regWrData[7:6], 2))
    else $error("register A write did not reach transmitter");

endmodule : stl_level_select

/* File: testbench/tb_top.sv */
// Self-checking bench for the transmitter level select block
`timescale 1ns/10ps
module tb_top;
  import stl_pkg::*;
  logic clk;
  logic nrst;
  logic clkEn;
  stl_phy_t phyState;
  logic [3:0] regAddr;
  logic [31:0] regWrData;
  logic regWrite;
  logic regRead;
  logic [31:0] regRdData;
  stl_tx_t txSettings;
  stl_mode_t activeMode;
  logic [31:0] expA;
  logic [31:0] expB;
  logic [31:0] rdVal;
  logic [31:0] d;
  int n_fail;
  int checks;
  int cyc;

  stl_level_select uut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .phyState(phyState),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .txSettings(txSettings), .activeMode(activeMode));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic stl_mode_t modeOf(stl_phy_t p);
    if (p.lowSwing) return p.rateR2 ? STL_LOW_R2 : STL_LOW_R1;
    if (!p.rateR2) return STL_FULL_R1_35;
    return p.deemph60 ? STL_FULL_R2_60 : STL_FULL_R2_35;
  endfunction : modeOf

  function automatic stl_tx_t expTx(stl_phy_t p, logic [31:0] a, logic [31:0] b);
    stl_tx_t t;
    t = '0;
    t.coarseSlew = p.rateR2 ? a[17:16] : a[13:12];
    t.fineSlew = p.rateR2 ? a[19:18] : a[15:14];
    t.deemphOn = ~p.lowSwing;
    case (modeOf(p))
      STL_FULL_R1_35: {t.driveLevel, t.fineDeemph, t.coarseDeemph, t.txEqual} =
        {b[4:0], b[7:5], a[1:0], a[3:2]};
      STL_FULL_R2_35: {t.driveLevel, t.fineDeemph, t.coarseDeemph, t.txEqual} =
        {b[12:8], b[15:13], a[5:4], a[7:6]};
      STL_FULL_R2_60: {t.driveLevel, t.fineDeemph, t.coarseDeemph, t.txEqual} =
        {b[20:16], b[23:21], a[9:8], a[11:10]};
      STL_LOW_R1: t.driveLevel = b[28:24];
      default: t.driveLevel = {2'b00, b[31:29]};
    endcase
    return t;
  endfunction : expTx

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    rdVal = regRdData;
  endtask : rd

  task automatic checkRegs();
    rd(STL_OFS_CTRL_A);
    chk("ctrlA", rdVal, expA);
    rd(STL_OFS_CTRL_B);
    chk("ctrlB", rdVal, expB);
  endtask : checkRegs

  task automatic checkOut();
    repeat (2) @(posedge clk);
    #1;
    chk("mode", 32'(activeMode), 32'(modeOf(phyState)));
    chk("tx", 32'(txSettings), 32'(expTx(phyState, expA, expB)));
  endtask : checkOut

  task automatic setPhy(input logic [2:0] p);
    @(posedge clk);
    phyState <= p;
    @(posedge clk);
    #1;
    chk("modeNext", 32'(activeMode), 32'(modeOf(p)));
    checkOut();
  endtask : setPhy

  task automatic doReset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    expA = STL_RST_CTRL_A;
    expB = STL_RST_CTRL_B;
  endtask : doReset

  task automatic end_sim();
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    nrst = 1'b0;
    clkEn = 1'b1;
    phyState = '0;
    regAddr = '0;
    regWrData = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    n_fail = 0;
    checks = 0;
    d = $urandom(55);
    doReset();
    checkRegs();
    for (int m = 0; m < 8; m++) setPhy(m[2:0]);
    // Status and unmapped writes leave controls alone
    wr(STL_OFS_STATUS, 32'hFFFFFFFF);
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC);
    chk("unmapped", rdVal, 32'h0);
    rd(STL_OFS_STATUS);
    chk("status", rdVal, 32'(modeOf(phyState)));
    checkRegs();
    // Frozen while clock enable is low, write dropped
    @(posedge clk);
    clkEn <= 1'b0;
    phyState <= 3'b100;
    wr(STL_OFS_CTRL_A, ~expA);
    @(posedge clk);
    #1;
    chk("frozen", 32'(activeMode), 32'(STL_LOW_R2));
    chk("frozenTx", 32'(txSettings), 32'(expTx(3'b111, expA, expB)));
    @(posedge clk);
    clkEn <= 1'b1;
    checkOut();
    checkRegs();
    // Rate 1 drive sweep, mode held steady
    setPhy(3'b000);
    wr(STL_OFS_CTRL_A, 32'h0000200B);
    expA = 32'h0000200B;
    for (int v = 0; v <= 32'h1C; v++) begin
      wr(STL_OFS_CTRL_B, {expB[31:5], 5'(v)});
      expB = {expB[31:5], 5'(v)};
      checkOut();
    end
    checkRegs();
    // Live update of the active mode
    for (int i = 0; i < 40; i++) begin
      setPhy(3'($urandom));
      d = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h0 : $urandom);
      wr(STL_OFS_CTRL_A, d);
      expA = d & STL_MASK_CTRL_A;
      checkOut();
      d = (i == 0) ? 32'hFFFFFFFF : ((i == 1) ? 32'h0 : $urandom);
      wr(STL_OFS_CTRL_B, d);
      expB = d & STL_MASK_CTRL_B;
      checkOut();
      checkRegs();
    end
    // Second reset restores defaults
    doReset();
    checkRegs();
    checkOut();
    end_sim();
  end
endmodule : tb_top
